// File: hdl/urxbg_map.svh
// Purpose: Register map, field positions and reset values of the receiver with baud generator
// Assumes: Wishbone classic slave, 32-bit data, byte addresses
// Notes:   Values in the low byte of each word, upper bits read as zero
`ifndef URXBG_MAP_SVH
`define URXBG_MAP_SVH

// ------------------------------------------------------------
// Offsets
// ------------------------------------------------------------
`define URXBG_OFF_MODE    4'h0
`define URXBG_OFF_ERR     4'h4
`define URXBG_OFF_BAUD    4'h8
`define URXBG_OFF_RXBUF   4'hC

// ------------------------------------------------------------
// Mode register fields
// ------------------------------------------------------------
`define URXBG_POWER_BIT   7
`define URXBG_TXEN_BIT    6
`define URXBG_RXEN_BIT    5
`define URXBG_PAR_HI_BIT  4
`define URXBG_PAR_LO_BIT  3
`define URXBG_LEN8_BIT    2
`define URXBG_STOP2_BIT   1

// ------------------------------------------------------------
// Error status fields
// ------------------------------------------------------------
`define URXBG_PERR_BIT    2
`define URXBG_FERR_BIT    1
`define URXBG_OVR_BIT     0

// ------------------------------------------------------------
// Baud divider fields and reset values
// ------------------------------------------------------------
`define URXBG_SEL_HI_BIT  7
`define URXBG_SEL_LO_BIT  6
`define URXBG_DIV_HI_BIT  4
`define URXBG_DIV_MIN     5'h08
`define URXBG_MODE_RST    8'h01
`define URXBG_BAUD_RST    8'h1F
`define URXBG_PRE_DIV2    5'h01
`define URXBG_PRE_DIV8    5'h07
`define URXBG_PRE_DIV32   5'h1F

`endif

// File: hdl/urxbg_pkg.sv
// Purpose: Types of the receiver with baud generator
// Assumes: Nothing beyond the map header
// Notes:   States are one-hot
package urxbg_pkg;

	typedef enum logic [4:0] {
		URXBG_IDLE  = 5'h01,
		URXBG_START = 5'h02,
		URXBG_DATA  = 5'h04,
		URXBG_PAR   = 5'h08,
		URXBG_STOP  = 5'h10
	} urxbg_state_t;

	typedef enum logic [1:0] {
		URXBG_PAR_NONE = 2'h0,
		URXBG_PAR_ZERO = 2'h1,
		URXBG_PAR_ODD  = 2'h2,
		URXBG_PAR_EVEN = 2'h3
	} urxbg_par_t;

endpackage : urxbg_pkg

// File: hdl/urxbg_top.sv
// Purpose: Receive side of an asynchronous serial port with its baud rate generator
// Assumes: 100 MHz clk_i, synchronous active-high reset, Wishbone classic registers
// Notes:   Transmit framing lives elsewhere; only the transmit divider is kept here
// Function
// [RL1] Sample the line only once power and then receive enable are set.
// [RL2] Falling edge starts receive counter; after divisor, resample, accept start if low.
// [RL3] Shift bits at the set rate; on stop, raise interrupt and load buffer.
// [RL4] On overrun the buffer keeps its earlier character.
// [RL5] Parity mismatch keeps receiving to stop, then signals error.
// [RL6] One receive interrupt for completion and errors.
// [RL7] Check exactly one stop bit; a second one is ignored.
// [RL8] Any error flag set by a frame raises the interrupt.
// [RL9] Reading error status clears all its bits.
// [RL10] Parity error when received parity disagrees with the configured type.
// [RL11] Framing error when the stop bit samples low.
// [RL12] Overrun when a frame ends before the buffer was read.
// [RL13] Software reads error status, then the buffer, after an error.
// [RL14] Line passes inward only after two base-clock samples agree.
// [RL15] Clock select picks timer output, or peripheral clock over 2, 8 or 32.
// [RL16] Base clock reaches the logic only while power is set.
// [RL17] Transmit counter held at zero unless powered and enabled; cleared on first write.
// [RL18] Receive counter held at zero when off; runs from start bit for one frame.
// [RL19] Two independent 5-bit divider counters, transmit and receive.
// [RL20] Divisor field sets k, legal from 8 to 31.
// [RL21] Bit rate is base clock over twice k.
// [RL22] Seven or eight data bits LSB first, optional even, odd or zero parity.
// [RL23] Zero parity and no parity never report a parity error.
// [RL24] Clearing power stops the clock and resets status and buffer.
// [RL25] Sample each later bit every 2k base clocks, near the centre.
//
// Our own choices: the Wishbone register port and the register addresses.
`include "urxbg_map.svh"

module urxbg_top
	import urxbg_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	// Serial line and timer source
	input  wire logic        serial_in_pin_i,
	input  wire logic        timer_output_source_i,
	// Events
	output logic             rx_done_irq_o,
	output logic             tx_load_i_unused_o,
	output logic             tx_tick_o
);

	// ------------------------------------------------------------
	// Registers and bus
	// ------------------------------------------------------------
	logic [7:0]   serial_mode_reg_ff;
	logic [7:0]   baud_divider_control_ff;
	logic [2:0]   rx_error_status_ff;
	logic [7:0]   rx_buffer_ff;
	logic         buf_full_ff;
	logic         tx_first_ff;
	logic         ack_ff;
	logic [31:0]  rdat_ff;
	logic         bus_req;
	logic         wr_lane0;
	logic         rd_err;
	logic         rd_buf;
	logic         unit_power_on;
	logic         tx_enable_bit;
	logic         rx_enable_bit;
	logic         rx_active;
	logic [4:0]   div_k;

	assign bus_req       = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wr_lane0      = bus_req & wb_we_i & wb_sel_i[0];
	assign rd_err        = bus_req & ~wb_we_i & (wb_adr_i == `URXBG_OFF_ERR);
	assign rd_buf        = bus_req & ~wb_we_i & (wb_adr_i == `URXBG_OFF_RXBUF);
	assign unit_power_on = serial_mode_reg_ff[`URXBG_POWER_BIT];
	assign tx_enable_bit = unit_power_on & serial_mode_reg_ff[`URXBG_TXEN_BIT];
	assign rx_enable_bit = unit_power_on & serial_mode_reg_ff[`URXBG_RXEN_BIT]; // [RL1]
	// Values below 8 are illegal; clamp so the sample point stays sane
	assign div_k = (baud_divider_control_ff[`URXBG_DIV_HI_BIT:0] < `URXBG_DIV_MIN) ?
	               `URXBG_DIV_MIN : baud_divider_control_ff[`URXBG_DIV_HI_BIT:0]; // [RL20]

	// Wrap test shared by the transmit and receive dividers
	function automatic logic at_top(input logic [4:0] cnt, input logic [4:0] k);
		return cnt == (k - 5'h1);
	endfunction : at_top

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ack_ff  <= 1'b0;
			rdat_ff <= 32'h0;
		end else begin
			ack_ff  <= bus_req;
			rdat_ff <= 32'h0;
			if (bus_req && !wb_we_i) begin
				case (wb_adr_i)
					`URXBG_OFF_MODE:  rdat_ff <= {24'h0, serial_mode_reg_ff};
					`URXBG_OFF_ERR:   rdat_ff <= {29'h0, rx_error_status_ff};
					`URXBG_OFF_BAUD:  rdat_ff <= {24'h0, baud_divider_control_ff};
					`URXBG_OFF_RXBUF: rdat_ff <= {24'h0, rx_buffer_ff};
					default:          rdat_ff <= 32'h0;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_err_o = 1'b0;
	assign wb_dat_o = rdat_ff;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			serial_mode_reg_ff      <= `URXBG_MODE_RST;
			baud_divider_control_ff <= `URXBG_BAUD_RST;
		end else if (wr_lane0) begin
			if (wb_adr_i == `URXBG_OFF_MODE)
				serial_mode_reg_ff <= wb_dat_i[7:0];
			if (wb_adr_i == `URXBG_OFF_BAUD)
				baud_divider_control_ff <= wb_dat_i[7:0];
		end
	end

	// ------------------------------------------------------------
	// Prescaler and base clock enable
	// ------------------------------------------------------------
	logic [4:0] pre_cnt_ff;
	logic [4:0] pre_top;
	logic       tmr_s1_ff;
	logic       tmr_s2_ff;
	logic       tmr_s3_ff;
	logic       base_tick;

	always_comb begin
		case (baud_divider_control_ff[`URXBG_SEL_HI_BIT:`URXBG_SEL_LO_BIT]) // [RL15]
			2'h1:    pre_top = `URXBG_PRE_DIV2;
			2'h2:    pre_top = `URXBG_PRE_DIV8;
			default: pre_top = `URXBG_PRE_DIV32;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !unit_power_on) begin
			pre_cnt_ff <= 5'h0;
			tmr_s1_ff  <= 1'b0;
			tmr_s2_ff  <= 1'b0;
			tmr_s3_ff  <= 1'b0;
		end else begin
			pre_cnt_ff <= (pre_cnt_ff >= pre_top) ? 5'h0 : pre_cnt_ff + 5'h1;
			tmr_s1_ff  <= timer_output_source_i;
			tmr_s2_ff  <= tmr_s1_ff;
			tmr_s3_ff  <= tmr_s2_ff;
		end
	end

	// Held low while unpowered
	always_comb begin
		if (!unit_power_on)
			base_tick = 1'b0; // [RL16]
		else if (baud_divider_control_ff[`URXBG_SEL_HI_BIT:`URXBG_SEL_LO_BIT] == 2'h0)
			base_tick = tmr_s2_ff & ~tmr_s3_ff; // [RL15]
		else
			base_tick = (pre_cnt_ff == pre_top);
	end

	// ------------------------------------------------------------
	// Transmit divider
	// ------------------------------------------------------------
	logic [4:0] tx_cnt_ff;

	assign tx_load_i_unused_o = 1'b0;

	// First transmit character write clears the count
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !tx_enable_bit) begin
			tx_cnt_ff   <= 5'h0; // [RL17]
			tx_first_ff <= 1'b1;
		end else if (tx_first_ff && wr_lane0 && wb_adr_i == `URXBG_OFF_RXBUF) begin
			tx_cnt_ff   <= 5'h0; // [RL17]
			tx_first_ff <= 1'b0;
		end else if (base_tick) begin
			tx_cnt_ff <= at_top(tx_cnt_ff, div_k) ? 5'h0 : tx_cnt_ff + 5'h1; // [RL19]
		end
	end

	// Half-bit tick; a transmitter toggles its bit every second one
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			tx_tick_o <= 1'b0;
		else
			tx_tick_o <= base_tick & tx_enable_bit & at_top(tx_cnt_ff, div_k);
	end

	// ------------------------------------------------------------
	// Line synchroniser and noise filter
	// ------------------------------------------------------------
	logic pin_s1_ff;
	logic pin_s2_ff;
	logic samp_a_ff;
	logic samp_b_ff;
	logic line_ff;
	logic line_prev_ff;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_s1_ff <= 1'b1;
			pin_s2_ff <= 1'b1;
		end else begin
			pin_s1_ff <= serial_in_pin_i;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// Line reads high while the receiver is off
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !rx_enable_bit) begin
			samp_a_ff    <= 1'b1;
			samp_b_ff    <= 1'b1;
			line_ff      <= 1'b1;
			line_prev_ff <= 1'b1;
		end else if (base_tick) begin
			samp_a_ff    <= pin_s2_ff;
			samp_b_ff    <= samp_a_ff;
			line_prev_ff <= line_ff;
			// A lone differing sample never reaches the engine
			if (samp_a_ff == samp_b_ff)
				line_ff <= samp_b_ff; // [RL14]
		end
	end

	// ------------------------------------------------------------
	// Receive engine
	// ------------------------------------------------------------
	urxbg_state_t state_ff;
	logic [4:0]   rx_cnt_ff;
	logic         half_ff;
	logic [2:0]   bit_idx_ff;
	logic [7:0]   rx_shift_reg_ff;
	logic         par_acc_ff;
	logic         perr_ff;
	logic         len8;
	urxbg_par_t   par_mode;
	logic         bit_end;
	logic         last_data;

	assign len8      = serial_mode_reg_ff[`URXBG_LEN8_BIT];
	assign par_mode  = urxbg_par_t'(serial_mode_reg_ff[`URXBG_PAR_HI_BIT:`URXBG_PAR_LO_BIT]);
	assign rx_active = (state_ff != URXBG_IDLE);
	// One bit time is two passes of k base clocks
	assign bit_end   = base_tick & half_ff & at_top(rx_cnt_ff, div_k); // [RL21] [RL25]
	assign last_data = (bit_idx_ff == (len8 ? 3'h7 : 3'h6));

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !rx_enable_bit || !rx_active) begin
			rx_cnt_ff <= 5'h0; // [RL18]
			half_ff   <= 1'b0;
		end else if (base_tick) begin
			if (at_top(rx_cnt_ff, div_k)) begin
				rx_cnt_ff <= 5'h0; // [RL19]
				// Start wrap leaves half clear so later samples land mid bit
				half_ff   <= (state_ff == URXBG_START) ? 1'b0 : ~half_ff; // [RL25]
			end else begin
				rx_cnt_ff <= rx_cnt_ff + 5'h1;
			end
		end
	end

	logic frame_done;
	logic frame_ferr;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !rx_enable_bit) begin
			state_ff        <= URXBG_IDLE;
			bit_idx_ff      <= 3'h0;
			rx_shift_reg_ff <= 8'h0;
			par_acc_ff      <= 1'b0;
			perr_ff         <= 1'b0;
			frame_done      <= 1'b0;
			frame_ferr      <= 1'b0;
		end else begin
			frame_done <= 1'b0;
			case (state_ff)
				URXBG_IDLE: begin
					if (base_tick && line_prev_ff && !line_ff) begin
						state_ff <= URXBG_START; // [RL2]
						perr_ff  <= 1'b0;
					end
				end
				// Resample after k base clocks: mid start bit
				URXBG_START: begin
					if (base_tick && at_top(rx_cnt_ff, div_k))
						state_ff <= line_ff ? URXBG_IDLE : URXBG_DATA; // [RL2]
					bit_idx_ff      <= 3'h0;
					par_acc_ff      <= 1'b0;
					rx_shift_reg_ff <= 8'h0;
				end
				URXBG_DATA: begin
					if (bit_end) begin
						rx_shift_reg_ff <= len8 ? {line_ff, rx_shift_reg_ff[7:1]}
						                        : {1'b0, line_ff, rx_shift_reg_ff[6:1]}; // [RL22]
						par_acc_ff <= par_acc_ff ^ line_ff;
						bit_idx_ff <= bit_idx_ff + 3'h1;
						if (last_data)
							state_ff <= (par_mode == URXBG_PAR_NONE) ? URXBG_STOP : URXBG_PAR;
					end
				end
				URXBG_PAR: begin
					if (bit_end) begin
						// Mismatch only noted; frame continues to stop
						case (par_mode)
							URXBG_PAR_EVEN: perr_ff <= par_acc_ff ^ line_ff; // [RL10] [RL5]
							URXBG_PAR_ODD:  perr_ff <= ~(par_acc_ff ^ line_ff); // [RL10] [RL5]
							default:        perr_ff <= 1'b0; // [RL23]
						endcase
						state_ff <= URXBG_STOP;
					end
				end
				URXBG_STOP: begin
					// Only one stop bit checked; idle re-arms before a second
					if (bit_end) begin
						frame_done <= 1'b1; // [RL7] [RL3]
						frame_ferr <= ~line_ff; // [RL11]
						state_ff   <= URXBG_IDLE; // [RL18]
					end
				end
				default: state_ff <= URXBG_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Buffer, error status and interrupt
	// ------------------------------------------------------------
	logic ovr_now;

	assign ovr_now = buf_full_ff & ~rd_buf; // [RL12]

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !unit_power_on) begin
			rx_buffer_ff <= 8'h0; // [RL24]
			buf_full_ff  <= 1'b0;
		end else if (frame_done && !ovr_now) begin // [RL4]
			rx_buffer_ff <= rx_shift_reg_ff; // [RL3]
			buf_full_ff  <= 1'b1;
		end else if (rd_buf) begin
			buf_full_ff <= 1'b0;
		end
	end

	// New error wins over a clearing read in the same cycle
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !unit_power_on) begin
			rx_error_status_ff <= 3'h0; // [RL24]
		end else if (frame_done) begin
			rx_error_status_ff <= (rd_err ? 3'h0 : rx_error_status_ff)
			                    | {perr_ff, frame_ferr, ovr_now}; // [RL4] [RL10] [RL11] [RL12]
		end else if (rd_err) begin
			rx_error_status_ff <= 3'h0; // [RL9]
		end
	end

	// Single pulse for completion and error alike
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			rx_done_irq_o <= 1'b0;
		else
			rx_done_irq_o <= frame_done; // [RL6] [RL8]
	end

endmodule : urxbg_top

// File: tb/urxbg_sva.sv
// Purpose: Port checks of urxbg_top
// Assumes: Mode enables in bits 7:5 of offset 0
// Notes:   Enable copy lags one edge, so checks look one cycle on
module urxbg_sva (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	// Bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	// Events
	input wire logic        rx_done_irq_o,
	input wire logic        tx_load_i_unused_o,
	input wire logic        tx_tick_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Enable copy
	// ----
	logic [2:0] en_ff;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			en_ff <= 3'h0;
		end else if (wb_ack_o && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0]) begin
			en_ff <= wb_dat_i[7:5];
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// ----
	// Properties
	// ----
	property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_ack_req; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_req: assert property (p_ack_req) else $error("ack missing");
	property p_ack_src; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
	a_ack_src: assert property (p_ack_src) else $error("ack without request");
	property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
	property p_err_low; !wb_err_o; endproperty
	a_err_low: assert property (p_err_low) else $error("bus error raised");
	property p_spare; !tx_load_i_unused_o; endproperty
	a_spare: assert property (p_spare) else $error("spare output high");
	property p_irq_pulse; rx_done_irq_o |=> !rx_done_irq_o [*8]; endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq not a pulse");
	property p_tick_gap; tx_tick_o |=> !tx_tick_o [*8]; endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
	property p_tick_off; !(en_ff[2] && en_ff[1]) |=> !tx_tick_o; endproperty
	a_tick_off: assert property (p_tick_off) else $error("tick while off");
	property p_irq_off; !(en_ff[2] && en_ff[0]) |=> !rx_done_irq_o; endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq while off");
endmodule : urxbg_sva
bind urxbg_top urxbg_sva u_sva (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.rx_done_irq_o(rx_done_irq_o), .tx_load_i_unused_o(tx_load_i_unused_o), .tx_tick_o(tx_tick_o));

// File: tb/urxbg_line_model.sv
// Purpose: Remote serial transmitter on the receive line
// Assumes: Bit time given in clk_i cycles
// Notes:   Good stop level is kept as idle, so frames may follow back to back
module urxbg_line_model (
	// Clock
	input  wire logic clk_i,
	// Line
	output logic      line_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial line_o = 1'b1;
	task automatic send(input logic [8:0] bits, input int nb, input logic stp, input int bt);
		line_o <= 1'b0;
		repeat (bt) @(posedge clk_i);
		for (int i = 0; i < nb; i++) begin
			line_o <= bits[i];
			repeat (bt) @(posedge clk_i);
		end
		line_o <= stp;
		repeat (bt) @(posedge clk_i);
		if (!stp) line_o <= 1'b1;
	endtask : send
	// Short low excursion, no frame behind it
	task automatic pulse(input int n);
		line_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		line_o <= 1'b1;
	endtask : pulse
endmodule : urxbg_line_model

// File: tb/tb_uart_receiver_baud_generator.sv
// Purpose: Self-checking bench of urxbg_top
// Assumes: Base clock clk/2 unless a case picks another
// Notes:   Timer source is clk/4, so its base tick is 4 cycles
module tb_uart_receiver_baud_generator;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i, sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, line, rx_done_irq_o, tx_tick_o;
	logic [3:0]  wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rdat;
	logic [1:0]  tmr_ff;
	int          fails, comparisons, irqs, ticks;
	urxbg_top u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .wb_err_o(), .serial_in_pin_i(line), .timer_output_source_i(tmr_ff[1]),
		.rx_done_irq_o(rx_done_irq_o), .tx_load_i_unused_o(), .tx_tick_o(tx_tick_o));
	urxbg_line_model u_line (.clk_i(clk_i), .line_o(line));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		tmr_ff <= tmr_ff + 2'h1;
		if (rx_done_irq_o === 1'b1) irqs <= irqs + 1;
		if (tx_tick_o === 1'b1) ticks <= ticks + 1;
	end
	// ----
	// Shared tasks
	// ----
	task automatic final_report;
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
		if (n == 20) begin
			fails++;
			final_report();
		end
	endtask : bus
	task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00);
		chk(nm, e, rdat);
	endtask : rchk
	task automatic cfg(input logic [7:0] bd, input logic [7:0] m);
		bus(1'b1, 4'h8, bd);
		bus(1'b1, 4'h0, m & 8'hDF);
		bus(1'b1, 4'h0, m);
	endtask : cfg
	// Idle gap after each frame keeps the next start edge clean
	task automatic frame(input logic [8:0] b, input int nb, input logic s, input int bt, input int ni);
		int i0;
		i0 = irqs;
		u_line.send(b, nb, s, bt);
		repeat (bt) @(posedge clk_i);
		chk("irq count", 32'(ni), 32'(irqs - i0));
	endtask : frame
	task automatic wait_tick(output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (tx_tick_o !== 1'b1 && n < 300);
		if (n == 300) begin
			fails++;
			final_report();
		end
	endtask : wait_tick
	// ----
	// Scenarios
	// ----
	task automatic t_regs;
		rchk("mode rst", 4'h0, 32'h01);
		rchk("baud rst", 4'h8, 32'h1F);
		rchk("err rst", 4'h4, 32'h0);
		bus(1'b1, 4'h2, 8'hFF);
		rchk("unmapped", 4'h2, 32'h0);
		bus(1'b1, 4'h8, 8'h48);
		rchk("baud rw", 4'h8, 32'h48);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_rates;
		logic [7:0] bd [5] = '{8'h48, 8'h88, 8'hC8, 8'h08, 8'h5F};
		int bt [5] = '{32, 128, 512, 64, 124};
		for (int i = 0; i < 5; i++) begin
			cfg(bd[i], 8'hA4);
			frame({1'b0, 8'h1C + 8'(i)}, 8, 1'b1, bt[i], 1);
			rchk("rate err", 4'h4, 32'h0);
			rchk("rate data", 4'hC, 32'h1C + 32'(i));
		end
		$display("t_rates done");
	endtask : t_rates
	task automatic t_parity;
		for (int pm = 0; pm < 4; pm++) begin
			cfg(8'h48, 8'hA4 | 8'(pm << 3));
			if (pm == 0) frame(9'h055, 8, 1'b1, 32, 1);
			else frame({pm != 2, 8'h55}, 9, 1'b1, 32, 1);
			rchk("perr", 4'h4, (pm >= 2) ? 32'h4 : 32'h0);
			rchk("perr clr", 4'h4, 32'h0);
			rchk("perr data", 4'hC, 32'h55);
			// Matching parity bit must pass clean
			if (pm >= 2) begin
				frame({pm == 2, 8'h55}, 9, 1'b1, 32, 1);
				rchk("par ok", 4'h4, 32'h0);
				rchk("par ok data", 4'hC, 32'h55);
			end
		end
		$display("t_parity done");
	endtask : t_parity
	task automatic t_stop;
		cfg(8'h48, 8'hA6);
		frame(9'h0F0, 8, 1'b0, 32, 1);
		rchk("ferr", 4'h4, 32'h2);
		rchk("ferr data", 4'hC, 32'hF0);
		$display("t_stop done");
	endtask : t_stop
	// One-clock spike is filtered; a short low fails the start check
	task automatic t_glitch;
		int i0;
		cfg(8'h48, 8'hA4);
		i0 = irqs;
		u_line.pulse(1);
		repeat (64) @(posedge clk_i);
		u_line.pulse(10);
		repeat (400) @(posedge clk_i);
		chk("glitch irqs", 32'h0, 32'(irqs - i0));
		frame(9'h05A, 8, 1'b1, 32, 1);
		rchk("glitch data", 4'hC, 32'h5A);
		$display("t_glitch done");
	endtask : t_glitch
	task automatic t_overrun;
		int i0;
		cfg(8'h48, 8'hA2);
		i0 = irqs;
		u_line.send(9'h02A, 7, 1'b1, 32);
		u_line.send(9'h055, 7, 1'b1, 32);
		repeat (32) @(posedge clk_i);
		chk("ovr irqs", 32'h2, 32'(irqs - i0));
		rchk("ovr err", 4'h4, 32'h1);
		rchk("ovr data", 4'hC, 32'h2A);
		frame(9'h011, 7, 1'b1, 32, 1);
		rchk("after ovr", 4'h4, 32'h0);
		rchk("next data", 4'hC, 32'h11);
		$display("t_overrun done");
	endtask : t_overrun
	task automatic t_power;
		int n;
		cfg(8'h48, 8'h84);
		frame(9'h0C3, 8, 1'b1, 32, 0);
		// Receiver off: buffer keeps the last character taken
		rchk("off data", 4'hC, 32'h11);
		cfg(8'h48, 8'hA4);
		frame(9'h0C3, 8, 1'b0, 32, 1);
		bus(1'b1, 4'h0, 8'h04);
		rchk("pwr err", 4'h4, 32'h0);
		rchk("pwr data", 4'hC, 32'h0);
		cfg(8'h48, 8'hC4);
		wait_tick(n);
		wait_tick(n);
		chk("tick gap", 32'd16, 32'(n));
		bus(1'b1, 4'h0, 8'h84);
		// Let a tick already in flight be counted first
		repeat (2) @(posedge clk_i);
		n = ticks;
		repeat (64) @(posedge clk_i);
		chk("tick off", 32'(n), 32'(ticks));
		$display("t_power done");
	endtask : t_power
	initial begin
		sys_rst_i = 1'b1;
		wb_cyc_i  = 1'b0;
		wb_stb_i  = 1'b0;
		wb_we_i   = 1'b0;
		wb_adr_i  = 4'h0;
		wb_dat_i  = 32'h0;
		tmr_ff    = 2'h0;
		repeat (8) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_rates();
		t_parity();
		t_stop();
		t_glitch();
		t_overrun();
		t_power();
		final_report();
	end
endmodule : tb_uart_receiver_baud_generator
